// [mmu_ctrl_map.vh]
// Constants for the memory-management control block: opcodes, register
// indices, bus transaction types and fixed real-mode memory attributes.
// Assumes it is included by mmu_ctrl.v and by the verification files.
`ifndef MMU_CTRL_MAP_VH
`define MMU_CTRL_MAP_VH

// ************************************************************
// Instruction opcodes presented on opCode.
// ************************************************************
`define OP_MTSR        4'h0
`define OP_MTSRIN      4'h1
`define OP_MFSR        4'h2
`define OP_MFSRIN      4'h3
`define OP_TLBIE       4'h4
`define OP_TLBSYNC     4'h5
`define OP_TLBIA       4'h6
`define OP_MTSPR       4'h7
`define OP_MFSPR       4'h8

// ************************************************************
// Special-register index: 0..15 block registers, 16 table base.
// Block index bit 3 is data side, bits 2:1 the pair, bit 0 lower.
// ************************************************************
`define SPR_BLK_LAST   5'h0F
`define SPR_PT_BASE    5'h10
`define SPR_DATA_BIT   3

// ************************************************************
// Bus transaction types and field positions.
// ************************************************************
`define BUS_INVAL      1'b0
`define BUS_SYNC       1'b1
`define SEG_SEL_MSB    31
`define SEG_SEL_LSB    28
`define SEG_DIRECT_BIT 31
`define SEG_BUID_MSB   28
`define SEG_BUID_LSB   20
`define SEG_VSID_MSB   23

// ************************************************************
// Reset values and real-mode memory attributes.
// ************************************************************
`define REG_RESET      32'h0000_0000
`define ATTR_DATA_REAL 4'h3
`define ATTR_INSN_REAL 4'h1

`endif

// [mmu_ctrl.v]
// Memory-management control: segment, block and table-base registers,
// entry invalidation with bus broadcast and sync, and real-mode pass-through.
// Assumes one core clock; the translation path and TLB arrays are outside.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_ctrl_map.vh"

module mmu_ctrl #(
	parameter CLASS_BITS = 6,
	parameter CLASS_LSB  = 12
) (
	input  wire                  mclk,
	input  wire                  rst_b,
	input  wire                  opValid,
	input  wire [3:0]            opCode,
	input  wire [3:0]            opSrIdx,
	input  wire [4:0]            opSprIdx,
	input  wire [31:0]           opRs,
	input  wire [31:0]           opRb,
	input  wire                  supervisor,
	output reg                   opReady,
	output reg                   opDone,
	output reg  [31:0]           opResult,
	output reg                   illegalOp,
	output reg                   privFault,
	output reg                   busReq,
	output reg                   busType,
	output reg  [31:0]           busAddr,
	input  wire                  busAck,
	input  wire                  snoopValid,
	input  wire                  snoopType,
	input  wire [31:0]           snoopAddr,
	output reg                   snoopRetry,
	output reg                   snoopSyncAck,
	output reg                   lclInvReq,
	output reg  [CLASS_BITS-1:0] lclInvClass,
	input  wire                  lclInvDone,
	input  wire                  insnTranslateEnable,
	input  wire                  dataTranslateEnable,
	input  wire                  fetchValid,
	input  wire [31:0]           fetchEffectiveAddress,
	input  wire                  dataValid,
	input  wire [31:0]           dataEffectiveAddress,
	output reg                   fetchRealValid,
	output reg                   fetchXlatValid,
	output reg  [31:0]           fetchPhysAddr,
	output reg  [3:0]            fetchMemoryAttributeBits,
	output reg                   dataRealValid,
	output reg                   dataXlatValid,
	output reg  [31:0]           dataPhysAddr,
	output reg  [3:0]            dataMemoryAttributeBits,
	output reg                   segDirectStore,
	output reg  [23:0]           segIdent,
	output reg  [511:0]          blockRegsFlat,
	output reg  [31:0]           pageTableBaseReg
);

	// ************************************************************
	// State of the own-instruction sequencer.
	// ************************************************************
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_INV  = 2'd1;
	localparam [1:0] ST_BUS  = 2'd2;

	reg  [1:0]            state_ff;
	reg  [1:0]            nxt_state;
	reg  [31:0]           segment_regs_ff [0:15];
	reg  [31:0]           block_regs_ff [0:15];
	reg  [31:0]           ownAddr_ff;
	reg                   ownInvPend_ff;
	reg                   snpPend_ff;
	reg  [CLASS_BITS-1:0] snpClass_ff;
	reg                   syncPend_ff;
	reg                   invFromSnoop_ff;
	integer               i, j;

	wire [3:0]  srSel;
	wire [31:0] segData;
	wire        opIsSeg;
	wire        opIsSpr;
	wire        opKnown;
	wire        sprLegal;
	wire        accept;
	wire        engineIdle;

	assign accept = opValid && opReady;
	// Indirect forms pick the segment from the top four bits of rB.
	assign srSel = (opCode == `OP_MTSRIN || opCode == `OP_MFSRIN) ?
		opRb[`SEG_SEL_MSB:`SEG_SEL_LSB] : opSrIdx;
	assign opIsSeg = (opCode == `OP_MTSR) || (opCode == `OP_MTSRIN) ||
		(opCode == `OP_MFSR) || (opCode == `OP_MFSRIN);
	assign opIsSpr = (opCode == `OP_MTSPR) || (opCode == `OP_MFSPR);
	assign sprLegal = (opSprIdx <= `SPR_PT_BASE);
	// Invalidate-all is deliberately left out of the known set.
	assign opKnown = opIsSeg || (opCode == `OP_TLBIE) ||
		(opCode == `OP_TLBSYNC) || (opIsSpr && sprLegal);
	assign segData = segment_regs_ff[dataEffectiveAddress[
		`SEG_SEL_MSB:`SEG_SEL_LSB]];
	assign engineIdle = !lclInvReq && !snpPend_ff;

	// ************************************************************
	// Instruction sequencer and register moves.
	// ************************************************************
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (accept && supervisor && opKnown)
				begin
					if (opCode == `OP_TLBIE)
						nxt_state = ST_INV;
					else if (opCode == `OP_TLBSYNC)
						nxt_state = ST_BUS;
				end
			end
			ST_INV:
			begin
				if (lclInvReq && !invFromSnoop_ff && lclInvDone)
					nxt_state = ST_BUS;
			end
			ST_BUS:
			begin
				if (busAck)
					nxt_state = ST_IDLE;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff <= ST_IDLE;
			opReady <= 1'b0;
			opDone <= 1'b0;
			opResult <= `REG_RESET;
			illegalOp <= 1'b0;
			privFault <= 1'b0;
			busReq <= 1'b0;
			busType <= `BUS_INVAL;
			busAddr <= `REG_RESET;
			ownAddr_ff <= `REG_RESET;
			ownInvPend_ff <= 1'b0;
			pageTableBaseReg <= `REG_RESET;
			for (i = 0; i < 16; i = i + 1)
			begin
				segment_regs_ff[i] <= `REG_RESET;
				block_regs_ff[i] <= `REG_RESET;
			end
		end
		else
		begin
			state_ff <= nxt_state;
			opReady <= (nxt_state == ST_IDLE);
			opDone <= 1'b0;
			illegalOp <= 1'b0;
			privFault <= 1'b0;
			if (accept)
			begin
				if (!opKnown)
					illegalOp <= 1'b1;
				else if (!supervisor)
					privFault <= 1'b1;
				else
				begin
					case (opCode)
						`OP_MTSR, `OP_MTSRIN:
						begin
							segment_regs_ff[srSel] <= opRs;
							opDone <= 1'b1;
						end
						`OP_MFSR, `OP_MFSRIN:
						begin
							opResult <= segment_regs_ff[srSel];
							opDone <= 1'b1;
						end
						`OP_MTSPR:
						begin
							if (opSprIdx == `SPR_PT_BASE)
								pageTableBaseReg <= opRs;
							else
								block_regs_ff[opSprIdx[3:0]] <= opRs;
							opDone <= 1'b1;
						end
						`OP_MFSPR:
						begin
							if (opSprIdx == `SPR_PT_BASE)
								opResult <= pageTableBaseReg;
							else
								opResult <= block_regs_ff[opSprIdx[3:0]];
							opDone <= 1'b1;
						end
						`OP_TLBIE:
						begin
							ownAddr_ff <= opRb;
							ownInvPend_ff <= 1'b1;
						end
						`OP_TLBSYNC:
						begin
							busReq <= 1'b1;
							busType <= `BUS_SYNC;
							busAddr <= `REG_RESET;
						end
						default:
							illegalOp <= 1'b1;
					endcase
				end
			end
			// Broadcast only once the local class is gone, so peers never
			// see the invalidation ahead of this processor.
			if (state_ff == ST_INV && lclInvReq && !invFromSnoop_ff &&
				lclInvDone)
			begin
				busReq <= 1'b1;
				busType <= `BUS_INVAL;
				busAddr <= ownAddr_ff;
			end
			if (lclInvReq && !invFromSnoop_ff)
				ownInvPend_ff <= 1'b0;
			if (state_ff == ST_BUS && busAck)
			begin
				busReq <= 1'b0;
				opDone <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Local invalidation engine, shared by own and snooped requests.
	// Snooped work goes first so a pending sync is never starved.
	// ************************************************************
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lclInvReq <= 1'b0;
			lclInvClass <= {CLASS_BITS{1'b0}};
			invFromSnoop_ff <= 1'b0;
			snpPend_ff <= 1'b0;
			snpClass_ff <= {CLASS_BITS{1'b0}};
			syncPend_ff <= 1'b0;
			snoopRetry <= 1'b0;
			snoopSyncAck <= 1'b0;
		end
		else
		begin
			snoopRetry <= 1'b0;
			snoopSyncAck <= 1'b0;
			if (lclInvReq && lclInvDone)
				lclInvReq <= 1'b0;
			else if (!lclInvReq && snpPend_ff)
			begin
				lclInvReq <= 1'b1;
				lclInvClass <= snpClass_ff;
				invFromSnoop_ff <= 1'b1;
				snpPend_ff <= 1'b0;
			end
			else if (!lclInvReq && ownInvPend_ff)
			begin
				lclInvReq <= 1'b1;
				lclInvClass <= ownAddr_ff[CLASS_LSB +: CLASS_BITS];
				invFromSnoop_ff <= 1'b0;
			end
			// A one-deep snoop buffer; a second invalidate while full is
			// pushed back to the bus for retry rather than dropped.
			if (snoopValid && snoopType == `BUS_INVAL)
			begin
				if (snpPend_ff && !(!lclInvReq))
					snoopRetry <= 1'b1;
				else if (snpPend_ff)
					snoopRetry <= 1'b1;
				else
				begin
					snpPend_ff <= 1'b1;
					snpClass_ff <= snoopAddr[CLASS_LSB +: CLASS_BITS];
				end
			end
			if (syncPend_ff && engineIdle && !(snoopValid &&
				snoopType == `BUS_INVAL))
			begin
				syncPend_ff <= 1'b0;
				snoopSyncAck <= 1'b1;
			end
			if (snoopValid && snoopType == `BUS_SYNC)
				syncPend_ff <= 1'b1;
		end
	end

	// ************************************************************
	// Real-mode pass-through and segment decode for the access paths.
	// ************************************************************
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetchRealValid <= 1'b0;
			fetchXlatValid <= 1'b0;
			fetchPhysAddr <= `REG_RESET;
			fetchMemoryAttributeBits <= 4'h0;
			dataRealValid <= 1'b0;
			dataXlatValid <= 1'b0;
			dataPhysAddr <= `REG_RESET;
			dataMemoryAttributeBits <= 4'h0;
			segDirectStore <= 1'b0;
			segIdent <= 24'h00_0000;
			blockRegsFlat <= {512{1'b0}};
		end
		else
		begin
			fetchRealValid <= fetchValid && !insnTranslateEnable;
			fetchXlatValid <= fetchValid && insnTranslateEnable;
			fetchPhysAddr <= fetchEffectiveAddress;
			fetchMemoryAttributeBits <= `ATTR_INSN_REAL;
			dataRealValid <= dataValid && !dataTranslateEnable;
			dataXlatValid <= dataValid && dataTranslateEnable;
			dataPhysAddr <= dataEffectiveAddress;
			dataMemoryAttributeBits <= `ATTR_DATA_REAL;
			// Bit 0 (the top bit) chooses direct-store or ordinary layout.
			segDirectStore <= segData[`SEG_DIRECT_BIT];
			if (segData[`SEG_DIRECT_BIT])
				segIdent <= {15'h0000,
					segData[`SEG_BUID_MSB:`SEG_BUID_LSB]};
			else
				segIdent <= segData[`SEG_VSID_MSB:0];
			for (j = 0; j < 16; j = j + 1)
				blockRegsFlat[j*32 +: 32] <= block_regs_ff[j];
		end
	end

endmodule // mmu_ctrl

`default_nettype wire

// [mmu_ctrl_assertions.sv]
// Checker for mmu_ctrl: real mode, faults, bus and snoop sync.
// Assumes the mmu_ctrl ports and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_ctrl_map.vh"
module mmu_ctrl_chk (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        opValid,
	input wire logic [3:0]  opCode,
	input wire logic        supervisor,
	input wire logic        opReady,
	input wire logic        opDone,
	input wire logic        illegalOp,
	input wire logic        privFault,
	input wire logic        busReq,
	input wire logic        busType,
	input wire logic [31:0] busAddr,
	input wire logic        busAck,
	input wire logic        snoopSyncAck,
	input wire logic        lclInvReq,
	input wire logic        dataValid,
	input wire logic        dataTranslateEnable,
	input wire logic [31:0] dataEffectiveAddress,
	input wire logic        dataRealValid,
	input wire logic [31:0] dataPhysAddr,
	input wire logic [3:0]  dataMemoryAttributeBits,
	input wire logic        fetchValid,
	input wire logic        insnTranslateEnable,
	input wire logic        fetchRealValid,
	input wire logic [3:0]  fetchMemoryAttributeBits
);
	logic taken;
	assign taken = opValid && opReady;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_data_real:
	assert property (dataValid && !dataTranslateEnable |=> dataRealValid
		&& dataMemoryAttributeBits == `ATTR_DATA_REAL)
		else $error("data real mode wrong");
	chk_fetch_real:
	assert property (fetchValid && !insnTranslateEnable |=> fetchRealValid
		&& fetchMemoryAttributeBits == `ATTR_INSN_REAL)
		else $error("fetch real mode wrong");
	chk_addr_pass:
	assert property (dataValid |=>
		dataPhysAddr == $past(dataEffectiveAddress))
		else $error("address not passed");
	chk_tlbia_illegal:
	assert property (taken && opCode == `OP_TLBIA |=> illegalOp && !opDone)
		else $error("invalidate-all not illegal");
	chk_priv_fault:
	assert property (taken && !supervisor && opCode < `OP_TLBIA
		|=> privFault && !opDone)
		else $error("user access not refused");
	chk_bus_hold:
	assert property (busReq && !busAck |=> busReq && $stable(busAddr)
		&& $stable(busType))
		else $error("bus request dropped early");
	chk_sync_bus:
	assert property (taken && supervisor && opCode == `OP_TLBSYNC
		|-> ##[1:60] busReq && busType && busAddr == 32'h0000_0000)
		else $error("sync transaction missing");
	chk_sync_wait:
	assert property (snoopSyncAck |-> !$past(lclInvReq))
		else $error("sync acked during invalidation");
endmodule // mmu_ctrl_chk
bind mmu_ctrl mmu_ctrl_chk u_chk (
	.mclk(mclk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
	.supervisor(supervisor), .opReady(opReady), .opDone(opDone),
	.illegalOp(illegalOp), .privFault(privFault), .busReq(busReq),
	.busType(busType), .busAddr(busAddr), .busAck(busAck),
	.snoopSyncAck(snoopSyncAck), .lclInvReq(lclInvReq),
	.dataValid(dataValid), .dataTranslateEnable(dataTranslateEnable),
	.dataEffectiveAddress(dataEffectiveAddress),
	.dataRealValid(dataRealValid), .dataPhysAddr(dataPhysAddr),
	.dataMemoryAttributeBits(dataMemoryAttributeBits),
	.fetchValid(fetchValid), .insnTranslateEnable(insnTranslateEnable),
	.fetchRealValid(fetchRealValid),
	.fetchMemoryAttributeBits(fetchMemoryAttributeBits)
);
`default_nettype wire

// [bus_peer_model.sv]
// Far side: peers accepting bus transactions, and the local TLB array.
// Assumes the core clock; slow stretches every answer.
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic slow,
	input  wire logic busReq,
	input  wire logic lclInvReq,
	output var  logic busAck,
	output var  logic lclInvDone
);
	logic [3:0] busCnt_ff;
	logic [3:0] invCnt_ff;
	logic [3:0] ansDelay;
	assign ansDelay = slow ? 4'h7 : 4'h1;
	// Counts park past the delay, so a request still up is not answered twice.
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busCnt_ff <= 4'h0;
			invCnt_ff <= 4'h0;
			busAck <= 1'b0;
			lclInvDone <= 1'b0;
		end
		else
		begin
			busAck <= busReq && busCnt_ff == ansDelay;
			lclInvDone <= lclInvReq && invCnt_ff == ansDelay;
			busCnt_ff <= busReq ? busCnt_ff + {3'h0, busCnt_ff <= ansDelay} : 4'h0;
			invCnt_ff <= lclInvReq ? invCnt_ff + {3'h0, invCnt_ff <= ansDelay}
				: 4'h0;
		end
	end
endmodule // bus_peer_model
`default_nettype wire

// [mmu_ctrl_tb_top.sv]
// Self-checking bench for mmu_ctrl with the bus peer model.
// Assumes the opcode constants of mmu_ctrl_map.vh and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_ctrl_map.vh"
module mmu_ctrl_tb_top;
	localparam logic [31:0] VA = 32'h8A5F_0123;
	localparam logic [31:0] VB = 32'h1234_5678;
	typedef struct packed {logic [3:0] c; logic [4:0] s;
		logic [31:0] a; logic [31:0] b; logic [31:0] r;} row_t;
	row_t rows [0:7];
	logic mclk = 0, rst_b = 0, opValid = 0, supervisor = 1, slow = 0;
	logic [3:0] opCode = 0, opSrIdx = 0;
	logic [4:0] opSprIdx = 0;
	logic [31:0] opRs = 0, opRb = 0, snoopAddr = 0;
	logic snoopValid = 0, snoopType = 0, fetchValid = 0, dataValid = 0;
	logic insnTranslateEnable = 0, dataTranslateEnable = 0;
	logic [31:0] fetchEffectiveAddress = 0, dataEffectiveAddress = 0;
	logic opReady, opDone, illegalOp, privFault, busReq, busType, busAck;
	logic snoopRetry, snoopSyncAck, lclInvReq, lclInvDone, segDirectStore;
	logic fetchRealValid, fetchXlatValid, dataRealValid, dataXlatValid;
	logic [31:0] opResult, busAddr, fetchPhysAddr, dataPhysAddr;
	logic [3:0] fetchMemoryAttributeBits, dataMemoryAttributeBits;
	logic [5:0] lclInvClass, lastClass;
	logic [23:0] segIdent;
	logic [511:0] blockRegsFlat;
	logic [31:0] pageTableBaseReg;
	logic [32:0] lastBus;
	logic [2:0] flags;
	integer fails = 0, comparisons = 0, cyc = 0, retries = 0, syncAcks = 0, i;
	mmu_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .opValid(opValid),
		.opCode(opCode), .opSrIdx(opSrIdx), .opSprIdx(opSprIdx), .opRs(opRs),
		.opRb(opRb), .supervisor(supervisor), .opReady(opReady),
		.opDone(opDone), .opResult(opResult), .illegalOp(illegalOp),
		.privFault(privFault), .busReq(busReq), .busType(busType),
		.busAddr(busAddr), .busAck(busAck), .snoopValid(snoopValid),
		.snoopType(snoopType), .snoopAddr(snoopAddr), .snoopRetry(snoopRetry),
		.snoopSyncAck(snoopSyncAck), .lclInvReq(lclInvReq),
		.lclInvClass(lclInvClass), .lclInvDone(lclInvDone),
		.insnTranslateEnable(insnTranslateEnable),
		.dataTranslateEnable(dataTranslateEnable), .fetchValid(fetchValid),
		.fetchEffectiveAddress(fetchEffectiveAddress), .dataValid(dataValid),
		.dataEffectiveAddress(dataEffectiveAddress),
		.fetchRealValid(fetchRealValid), .fetchXlatValid(fetchXlatValid),
		.fetchPhysAddr(fetchPhysAddr), .dataRealValid(dataRealValid),
		.fetchMemoryAttributeBits(fetchMemoryAttributeBits),
		.dataXlatValid(dataXlatValid), .dataPhysAddr(dataPhysAddr),
		.dataMemoryAttributeBits(dataMemoryAttributeBits),
		.segDirectStore(segDirectStore), .segIdent(segIdent),
		.blockRegsFlat(blockRegsFlat), .pageTableBaseReg(pageTableBaseReg));
	bus_peer_model u_peer (.mclk(mclk), .rst_b(rst_b), .slow(slow),
		.busReq(busReq), .lclInvReq(lclInvReq), .busAck(busAck),
		.lclInvDone(lclInvDone));
	always #12.5 mclk = ~mclk;
	task end_sim;
	begin
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			fails = fails + 1;
			end_sim;
		end
	end
	always @(negedge mclk)
	begin
		if (lclInvReq === 1)
			lastClass = lclInvClass;
		if (busReq === 1)
			lastBus = {busType, busAddr};
		retries = retries + (snoopRetry === 1);
		syncAcks = syncAcks + (snoopSyncAck === 1);
	end
	// Every instruction goes through this one routine.
	task op(input logic [3:0] c, input logic [4:0] s,
		input logic [31:0] a, input logic [31:0] b);
		integer n;
	begin
		@(negedge mclk);
		{opCode, opSprIdx, opRs, opRb, opValid} = {c, s, a, b, 1'b1};
		opSrIdx = s[3:0];
		n = 0;
		while (opReady !== 1 && n < 300)
		begin
			@(negedge mclk);
			n = n + 1;
		end
		@(negedge mclk);
		opValid = 0;
		while (opDone !== 1 && illegalOp !== 1 && privFault !== 1 && n < 300)
		begin
			@(negedge mclk);
			n = n + 1;
		end
		flags = {illegalOp, privFault, opDone};
	end
	endtask
	initial
	begin
		rows[0] = {`OP_MTSR, 5'h03, VA, 32'h0, 32'h0};
		rows[1] = {`OP_MTSRIN, 5'h00, VB, 32'hF000_0000, 32'h0};
		rows[2] = {`OP_MFSR, 5'h03, 32'h0, 32'h0, VA};
		rows[3] = {`OP_MFSRIN, 5'h00, 32'h0, 32'hF000_0000, VB};
		rows[4] = {`OP_MTSPR, 5'h0D, 32'hC0DE_0001, 32'h0, VB};
		rows[5] = {`OP_MFSPR, 5'h0D, 32'h0, 32'h0, 32'hC0DE_0001};
		rows[6] = {`OP_MTSPR, 5'h10, 32'h5A5A_0000, 32'h0, 32'hC0DE_0001};
		rows[7] = {`OP_MFSPR, 5'h10, 32'h0, 32'h0, 32'h5A5A_0000};
		repeat (20) @(negedge mclk);
		rst_b = 1;
		for (i = 0; i < 8; i = i + 1)
		begin
			op(rows[i].c, rows[i].s, rows[i].a, rows[i].b);
			cmp({29'h0, flags}, 32'h1);
			cmp(opResult, rows[i].r);
		end
		cmp(blockRegsFlat[13*32 +: 32], 32'hC0DE_0001);
		cmp(pageTableBaseReg, 32'h5A5A_0000);
		{dataEffectiveAddress, fetchEffectiveAddress} = {32'h3000_1234, VB};
		{dataValid, fetchValid} = 2'b11;
		repeat (2) @(negedge mclk);
		cmp(dataPhysAddr, 32'h3000_1234);
		cmp(fetchPhysAddr, VB);
		cmp({22'h0, fetchRealValid, fetchMemoryAttributeBits, dataRealValid,
			dataMemoryAttributeBits}, 32'h233);
		cmp({7'h0, segDirectStore, segIdent}, 32'h0100_00A5);
		dataEffectiveAddress = 32'hF000_0000;
		{insnTranslateEnable, dataTranslateEnable} = 2'b11;
		repeat (2) @(negedge mclk);
		cmp({7'h0, segDirectStore, segIdent}, 32'h0034_5678);
		cmp({28'h0, fetchXlatValid, dataXlatValid, fetchRealValid,
			dataRealValid}, 32'hC);
		{dataValid, fetchValid} = 2'b00;
		op(`OP_TLBIA, 5'h0, 32'h0, 32'h0);
		cmp({29'h0, flags}, 32'h4);
		op(`OP_MFSPR, 5'h11, 32'h0, 32'h0);
		cmp({29'h0, flags}, 32'h0000_0004);
		supervisor = 0;
		op(`OP_MTSR, 5'h0F, 32'h0, 32'h0);
		cmp({29'h0, flags}, 32'h2);
		op(`OP_MTSPR, 5'h10, 32'hFFFF_FFFF, 32'h0);
		cmp({29'h0, flags}, 32'h0000_0002);
		supervisor = 1;
		cmp({8'h0, segIdent}, 32'h0034_5678);
		cmp(pageTableBaseReg, 32'h5A5A_0000);
		slow = 1;
		op(`OP_TLBIE, 5'h0, 32'h0, 32'h0003_5000);
		cmp({26'h0, lastClass}, 32'h0000_0035);
		cmp({29'h0, flags}, 32'h0000_0001);
		cmp(lastBus[31:0], 32'h0003_5000);
		cmp({31'h0, lastBus[32]}, 32'h0000_0000);
		op(`OP_TLBSYNC, 5'h0, 32'h0, 32'h0);
		cmp({30'h0, lastBus[32], flags[0]}, 32'h3);
		cmp(lastBus[31:0], 32'h0000_0000);
		for (i = 0; i < 4; i = i + 1)
		begin
			@(negedge mclk);
			{snoopValid, snoopType, snoopAddr} = {i < 3, i > 1, 32'h0001_1000};
		end
		@(negedge mclk);
		snoopValid = 0;
		for (i = 0; i < 100 && syncAcks == 0; i = i + 1)
			@(negedge mclk);
		cmp({30'h0, retries != 0, syncAcks == 1}, 32'h3);
		cmp({26'h0, lastClass}, 32'h11);
		rst_b = 0;
		@(negedge mclk);
		cmp({27'h0, opReady, dataMemoryAttributeBits}, 32'h0);
		rst_b = 1;
		op(`OP_MFSR, 5'h03, 32'h0, 32'h0);
		cmp({29'h0, flags}, 32'h0000_0001);
		cmp(opResult | pageTableBaseReg, `REG_RESET);
		end_sim;
	end
endmodule // mmu_ctrl_tb_top
`default_nettype wire
